// file: hdl/chgsc_pkg.sv
// constants and types shared by the charger status and control logic
package chgsc_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ = 125_000_000; // MCLK rate
	localparam int unsigned HIB_DEBOUNCE_MS = 32; // hibernate request hold time
	localparam int unsigned HIB_DEBOUNCE_CYC = (CLK_HZ / 1000) * HIB_DEBOUNCE_MS; // least time

	// ****************************************
	// termination targets in millivolts
	// ****************************************
	localparam logic [12:0] TERM_LOW_MV = 13'd4100; // lower clamp
	localparam logic [12:0] TERM_HIGH_MV = 13'd4160; // higher clamp

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0] REG_CONTROL = 8'h00; // bit0 soft charge disable
	localparam logic [7:0] REG_STATUS = 8'h04; // live state, read only
	localparam logic [7:0] REG_INT_STAT = 8'h08; // sticky events, write one to clear
	localparam logic [7:0] REG_INT_MASK = 8'h0c; // interrupt enables
	localparam logic [31:0] RESET_CONTROL = 32'h0000_0000;
	localparam logic [4:0] RESET_INT_MASK = 5'h00;
	localparam int unsigned NUM_EVENTS = 5; // event bits

	// event bit positions
	localparam int unsigned EV_CHARGER_ON = 0;
	localparam int unsigned EV_CHARGER_OFF = 1;
	localparam int unsigned EV_TRICKLE = 2;
	localparam int unsigned EV_HIBERNATE = 3;
	localparam int unsigned EV_LOAD_FAULT = 4;

	// ****************************************
	// charge drive modes
	// ****************************************
	typedef enum logic [1:0] {
		DRV_OFF = 2'b00, // no charge current
		DRV_SATURATE = 2'b01, // pass transistor saturated
		DRV_REGULATE = 2'b11, // regulate to clamp voltage
		DRV_REDUCED = 2'b10 // power limited
	} chgsc_drive_t;

	// charge control states, gray along idle-full-trickle
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FULL = 2'b01,
		ST_TRICKLE = 2'b11
	} chgsc_state_t;

	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;

endpackage

// file: hdl/chgsc_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module chgsc_sync #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1; // first stage, read only by stage two
	logic [WIDTH-1:0] stage2; // settled copy
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_stage2;

	// next values
	always_comb begin
		next_stage1 = din;
		next_stage2 = stage1;
	end

	// registers, cleared to zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign dout = stage2;
endmodule // chgsc_sync
`default_nettype wire

// file: hdl/chgsc_top.sv
// charger status and control logic with axi4-lite register slave
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module chgsc_top #(
	parameter int unsigned HIB_CYCLES = chgsc_pkg::HIB_DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// host logic pins
	input wire logic CHARGE_DISABLE,
	input wire logic CHEMISTRY_HIGH,
	input wire logic HIBERNATE_REQUEST,
	input wire logic HIBERNATE_RELEASE_N,
	input wire logic BATTERY_PRESENT_N,
	// analog comparator indications
	input wire logic CHARGER_CONFIRMED,
	input wire logic CELL_ABOVE_PHONE_ON,
	input wire logic CELL_ABOVE_LOW,
	input wire logic CELL_HIGH_CHARGE,
	input wire logic PASS_OVERPOWER,
	input wire logic LOAD_OVERCURRENT,
	// open-drain outputs
	output logic CHARGE_PHASE_FLAG_O,
	output logic CHARGE_PHASE_FLAG_OE,
	output logic CHARGER_SEEN_O,
	output logic CHARGER_SEEN_OE,
	// push-pull and analog commands
	output logic EXTERNAL_POWER_OK,
	output logic LOAD_SWITCH_ON,
	output logic [1:0] CHARGE_DRIVE,
	output logic TERMINATION_HIGH,
	output logic IRQ,
	// axi4-lite write address
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// axi4-lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read address
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// axi4-lite read data
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	localparam int unsigned NE = chgsc_pkg::NUM_EVENTS;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [10:0] pins_raw; // raw pin bundle
	logic [10:0] pins; // synchronised bundle
	assign pins_raw = {LOAD_OVERCURRENT, PASS_OVERPOWER, CELL_HIGH_CHARGE, CELL_ABOVE_LOW,
		CELL_ABOVE_PHONE_ON, CHARGER_CONFIRMED, BATTERY_PRESENT_N, HIBERNATE_RELEASE_N,
		HIBERNATE_REQUEST, CHEMISTRY_HIGH, CHARGE_DISABLE};

	chgsc_sync #(.WIDTH(11)) u_sync (
		.clk(MCLK),
		.reset_n(RESET_N),
		.din(pins_raw),
		.dout(pins)
	);

	logic dis_pin, chem, hib_req, hib_rel_n, batt_n, chg_raw;
	logic cell_on, cell_low_ok, cell_full, overpower, overload;
	assign {overload, overpower, cell_full, cell_low_ok, cell_on, chg_raw, batt_n,
		hib_rel_n, hib_req, chem, dis_pin} = pins;

	// ****************************************
	// register state
	// ****************************************
	logic soft_disable, next_soft_disable; // software charge disable
	logic [NE-1:0] int_stat, next_int_stat; // sticky events
	logic [NE-1:0] int_mask, next_int_mask; // interrupt enables
	logic disable_any; // pin or software disable
	assign disable_any = dis_pin | soft_disable;

	// ****************************************
	// charge control
	// ****************************************
	chgsc_pkg::chgsc_state_t state, next_state; // charge phase
	logic disable_d, next_disable_d; // previous disable level
	logic charger_ok; // presence gated by battery
	logic disable_fall; // re-enable edge

	// detection is only possible with a battery fitted
	assign charger_ok = chg_raw & ~batt_n;
	assign disable_fall = disable_d & ~disable_any;

	// next charge state
	always_comb begin
		next_disable_d = disable_any;
		next_state = state;
		if (!charger_ok || disable_fall) begin
			next_state = chgsc_pkg::ST_IDLE;
		end else begin
			case (state)
				chgsc_pkg::ST_IDLE: begin
					if (!disable_any) begin
						next_state = chgsc_pkg::ST_FULL;
					end
				end
				chgsc_pkg::ST_FULL: begin
					if (cell_full) begin
						next_state = chgsc_pkg::ST_TRICKLE;
					end
				end
				chgsc_pkg::ST_TRICKLE: begin
					next_state = chgsc_pkg::ST_TRICKLE;
				end
				default: begin
					next_state = chgsc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// charge state registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= chgsc_pkg::ST_IDLE;
			disable_d <= 1'b0;
		end else begin
			state <= next_state;
			disable_d <= next_disable_d;
		end
	end

	// ****************************************
	// hibernate latch and load switch
	// ****************************************
	logic [31:0] hib_count, next_hib_count; // hold timer
	logic hib_latch, next_hib_latch; // switch held open
	logic hib_done; // request held long enough
	assign hib_done = hib_req && (hib_count >= HIB_CYCLES - 1);

	// debounce counter and latch; release wins since it is the exit path
	always_comb begin
		next_hib_count = hib_req ? (hib_done ? hib_count : hib_count + 32'h1) : 32'h0;
		next_hib_latch = hib_latch;
		if (!hib_rel_n) begin
			next_hib_latch = 1'b0;
		end else if (hib_done) begin
			next_hib_latch = 1'b1;
		end
	end

	// hibernate registers, latch clear after reset
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hib_count <= 32'h0;
			hib_latch <= 1'b0;
		end else begin
			hib_count <= next_hib_count;
			hib_latch <= next_hib_latch;
		end
	end

	// ****************************************
	// output commands, all registered
	// ****************************************
	logic next_phase_low, next_seen, next_pwr_ok, next_load_on;
	chgsc_pkg::chgsc_drive_t next_drive;

	always_comb begin
		// open-drain phase: driven low only while full-rate and enabled
		next_phase_low = (state == chgsc_pkg::ST_FULL) && !disable_any;
		next_seen = charger_ok;
		next_pwr_ok = cell_on & charger_ok;
		// load switch opens on under-voltage, overload or hibernate
		next_load_on = cell_low_ok & ~overload & ~hib_latch;
		if (disable_any || state == chgsc_pkg::ST_IDLE) begin
			next_drive = chgsc_pkg::DRV_OFF;
		end else if (overpower) begin
			next_drive = chgsc_pkg::DRV_REDUCED;
		end else if (state == chgsc_pkg::ST_FULL) begin
			next_drive = chgsc_pkg::DRV_SATURATE;
		end else begin
			next_drive = chgsc_pkg::DRV_REGULATE;
		end
	end

	// output registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CHARGE_PHASE_FLAG_OE <= 1'b0;
			CHARGER_SEEN_OE <= 1'b0;
			EXTERNAL_POWER_OK <= 1'b0;
			LOAD_SWITCH_ON <= 1'b0;
			CHARGE_DRIVE <= chgsc_pkg::DRV_OFF;
			TERMINATION_HIGH <= 1'b0;
		end else begin
			CHARGE_PHASE_FLAG_OE <= next_phase_low;
			CHARGER_SEEN_OE <= next_seen;
			EXTERNAL_POWER_OK <= next_pwr_ok;
			LOAD_SWITCH_ON <= next_load_on;
			CHARGE_DRIVE <= next_drive;
			TERMINATION_HIGH <= chem;
		end
	end

	// open-drain pins only ever drive low
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CHARGE_PHASE_FLAG_O <= 1'b0;
			CHARGER_SEEN_O <= 1'b0;
		end else begin
			CHARGE_PHASE_FLAG_O <= 1'b0;
			CHARGER_SEEN_O <= 1'b0;
		end
	end

	// ****************************************
	// events and interrupt
	// ****************************************
	logic [NE-1:0] events; // one-cycle event pulses
	logic seen_d, hib_d, load_d; // previous levels
	logic [NE-1:0] w1c; // software clear bits
	assign events[chgsc_pkg::EV_CHARGER_ON] = charger_ok & ~seen_d;
	assign events[chgsc_pkg::EV_CHARGER_OFF] = ~charger_ok & seen_d;
	assign events[chgsc_pkg::EV_TRICKLE] = (next_state == chgsc_pkg::ST_TRICKLE) &&
		(state == chgsc_pkg::ST_FULL);
	assign events[chgsc_pkg::EV_HIBERNATE] = hib_latch & ~hib_d;
	assign events[chgsc_pkg::EV_LOAD_FAULT] = overload & ~load_d;

	// edge history
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			seen_d <= 1'b0;
			hib_d <= 1'b0;
			load_d <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			seen_d <= charger_ok;
			hib_d <= hib_latch;
			load_d <= overload;
			IRQ <= |(next_int_stat & next_int_mask);
		end
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid, next_arready;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic do_write;

	assign do_write = aw_held && w_held && !BVALID;

	// write channel, register file and read channel next values
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = BVALID;
		next_bresp = BRESP;
		next_rvalid = RVALID;
		next_rresp = RRESP;
		next_rdata = RDATA;
		next_arready = 1'b0;
		next_soft_disable = soft_disable;
		next_int_mask = int_mask;
		w1c = '0;
		if (AWVALID && AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_w_held = 1'b1;
			next_w_data = WDATA;
			next_w_strb = WSTRB;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = chgsc_pkg::AXI_OKAY;
			if (aw_addr[7:2] == chgsc_pkg::REG_CONTROL[7:2]) begin
				if (w_strb[0]) next_soft_disable = w_data[0];
			end else if (aw_addr[7:2] == chgsc_pkg::REG_INT_STAT[7:2]) begin
				if (w_strb[0]) w1c = w_data[NE-1:0];
			end else if (aw_addr[7:2] == chgsc_pkg::REG_INT_MASK[7:2]) begin
				if (w_strb[0]) next_int_mask = w_data[NE-1:0];
			end else if (aw_addr[7:2] != chgsc_pkg::REG_STATUS[7:2]) begin
				next_bresp = chgsc_pkg::AXI_SLVERR;
			end
		end else if (BVALID && BREADY) begin
			next_bvalid = 1'b0;
		end
		if (RVALID && RREADY) begin
			next_rvalid = 1'b0;
		end
		if (ARVALID && !RVALID && !ARREADY) begin
			next_arready = 1'b1;
		end
		if (ARVALID && ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp = chgsc_pkg::AXI_OKAY;
			next_rdata = 32'h0;
			if (ARADDR[7:2] == chgsc_pkg::REG_CONTROL[7:2]) begin
				next_rdata = {31'h0, soft_disable};
			end else if (ARADDR[7:2] == chgsc_pkg::REG_STATUS[7:2]) begin
				next_rdata = {22'h0, CHARGE_DRIVE, LOAD_SWITCH_ON, hib_latch,
					EXTERNAL_POWER_OK, CHARGER_SEEN_OE, TERMINATION_HIGH, state, dis_pin};
			end else if (ARADDR[7:2] == chgsc_pkg::REG_INT_STAT[7:2]) begin
				next_rdata = {27'h0, int_stat};
			end else if (ARADDR[7:2] == chgsc_pkg::REG_INT_MASK[7:2]) begin
				next_rdata = {27'h0, int_mask};
			end else begin
				next_rresp = chgsc_pkg::AXI_SLVERR;
			end
		end
		// a new event wins over a clear in the same cycle
		next_int_stat = (int_stat & ~w1c) | events;
	end

	// bus and register registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= chgsc_pkg::AXI_OKAY;
			RVALID <= 1'b0;
			RRESP <= chgsc_pkg::AXI_OKAY;
			RDATA <= 32'h0;
			ARREADY <= 1'b0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			soft_disable <= chgsc_pkg::RESET_CONTROL[0];
			int_mask <= chgsc_pkg::RESET_INT_MASK;
			int_stat <= '0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			BVALID <= next_bvalid;
			BRESP <= next_bresp;
			RVALID <= next_rvalid;
			RRESP <= next_rresp;
			RDATA <= next_rdata;
			ARREADY <= next_arready;
			AWREADY <= !next_aw_held && !(AWVALID && AWREADY);
			WREADY <= !next_w_held && !(WVALID && WREADY);
			soft_disable <= next_soft_disable;
			int_mask <= next_int_mask;
			int_stat <= next_int_stat;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	AST_DRIVE_OFF: assert property (@(posedge MCLK) disable iff (!RESET_N)
		disable_any |=> CHARGE_DRIVE == chgsc_pkg::DRV_OFF)
		else $error("drive not off while disabled");
	AST_REENABLE_IDLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
		disable_fall |=> state == chgsc_pkg::ST_IDLE)
		else $error("state not reset on re-enable");
	AST_CHEM: assert property (@(posedge MCLK) disable iff (!RESET_N)
		1'b1 |=> TERMINATION_HIGH == $past(chem))
		else $error("termination select wrong");
	AST_HIB_SET: assert property (@(posedge MCLK) disable iff (!RESET_N)
		hib_done && hib_rel_n |=> hib_latch)
		else $error("hibernate latch not set");
	AST_HIB_CLR: assert property (@(posedge MCLK) disable iff (!RESET_N)
		!hib_rel_n |=> !hib_latch)
		else $error("hibernate latch not cleared");
	AST_NO_BATT: assert property (@(posedge MCLK) disable iff (!RESET_N)
		batt_n |=> !CHARGER_SEEN_OE && !EXTERNAL_POWER_OK)
		else $error("charger seen without battery");
	AST_PHASE: assert property (@(posedge MCLK) disable iff (!RESET_N)
		state == chgsc_pkg::ST_TRICKLE |=> !CHARGE_PHASE_FLAG_OE)
		else $error("phase pin low in trickle");
	AST_PWR_OK: assert property (@(posedge MCLK) disable iff (!RESET_N)
		EXTERNAL_POWER_OK |-> $past(cell_on) && $past(charger_ok))
		else $error("power ok without cause");
	AST_LOAD: assert property (@(posedge MCLK) disable iff (!RESET_N)
		!cell_low_ok || overload |=> !LOAD_SWITCH_ON)
		else $error("load switch on during fault");
	AST_REDUCE: assert property (@(posedge MCLK) disable iff (!RESET_N)
		overpower && !disable_any && state != chgsc_pkg::ST_IDLE
		|=> CHARGE_DRIVE == chgsc_pkg::DRV_REDUCED)
		else $error("drive not reduced on overpower");
endmodule // chgsc_top
`default_nettype wire

// file: verif/chgsc_host_model.sv
// phone-side view of the open-drain status pins, with their pull-ups
`timescale 1ns/1ps
`default_nettype none
module chgsc_host_model (
	// charge phase pin from the device
	input wire logic phase_o,
	input wire logic phase_oe,
	// charger seen pin from the device
	input wire logic seen_o,
	input wire logic seen_oe,
	// wire levels as the phone reads them
	output logic phase_pin,
	output logic seen_pin
);
	// ****************************************
	// pull-up resolution
	// ****************************************
	// a released pin floats up to the rail, never holds the last value
	assign phase_pin = phase_oe ? phase_o : 1'b1;
	assign seen_pin = seen_oe ? seen_o : 1'b1;
endmodule // chgsc_host_model
`default_nettype wire

// file: verif/chgsc_top_test.sv
// self-checking bench for the charger status and control logic
`timescale 1ns/1ps
`default_nettype none
module chgsc_top_test;
	// ****************************************
	// stimulus and observation
	// ****************************************
	localparam int unsigned HIB = 16; // shortened hibernate debounce
	logic MCLK = 1'b0;
	logic RESET_N = 1'b0;
	logic CHARGE_DISABLE = 1'b0, CHEMISTRY_HIGH = 1'b0, HIBERNATE_REQUEST = 1'b0;
	logic HIBERNATE_RELEASE_N = 1'b1, BATTERY_PRESENT_N = 1'b1, CHARGER_CONFIRMED = 1'b0;
	logic CELL_ABOVE_PHONE_ON = 1'b1, CELL_ABOVE_LOW = 1'b1, CELL_HIGH_CHARGE = 1'b0;
	logic PASS_OVERPOWER = 1'b0, LOAD_OVERCURRENT = 1'b0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic phase_o, phase_oe, seen_o, seen_oe, phase_pin, seen_pin;
	logic EXTERNAL_POWER_OK, LOAD_SWITCH_ON, TERMINATION_HIGH, IRQ;
	logic [1:0] CHARGE_DRIVE, BRESP, RRESP, resp;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [31:0] RDATA, rdat;
	int error_cnt = 0; // mismatches
	int n_compared = 0; // comparisons made

	chgsc_top #(.HIB_CYCLES(HIB)) i_dut (
		.MCLK(MCLK), .RESET_N(RESET_N), .CHARGE_DISABLE(CHARGE_DISABLE),
		.CHEMISTRY_HIGH(CHEMISTRY_HIGH), .HIBERNATE_REQUEST(HIBERNATE_REQUEST),
		.HIBERNATE_RELEASE_N(HIBERNATE_RELEASE_N), .BATTERY_PRESENT_N(BATTERY_PRESENT_N),
		.CHARGER_CONFIRMED(CHARGER_CONFIRMED), .CELL_ABOVE_PHONE_ON(CELL_ABOVE_PHONE_ON),
		.CELL_ABOVE_LOW(CELL_ABOVE_LOW), .CELL_HIGH_CHARGE(CELL_HIGH_CHARGE),
		.PASS_OVERPOWER(PASS_OVERPOWER), .LOAD_OVERCURRENT(LOAD_OVERCURRENT),
		.CHARGE_PHASE_FLAG_O(phase_o), .CHARGE_PHASE_FLAG_OE(phase_oe),
		.CHARGER_SEEN_O(seen_o), .CHARGER_SEEN_OE(seen_oe),
		.EXTERNAL_POWER_OK(EXTERNAL_POWER_OK), .LOAD_SWITCH_ON(LOAD_SWITCH_ON),
		.CHARGE_DRIVE(CHARGE_DRIVE), .TERMINATION_HIGH(TERMINATION_HIGH), .IRQ(IRQ),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
		.WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
	);

	chgsc_host_model i_host (
		.phase_o(phase_o), .phase_oe(phase_oe), .seen_o(seen_o), .seen_oe(seen_oe),
		.phase_pin(phase_pin), .seen_pin(seen_pin)
	);

	// 125 MHz clock
	initial begin
		forever #4 MCLK = ~MCLK;
	end

	// ****************************************
	// compare, report and bus tasks
	// ****************************************
	task automatic chk_pin(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// a bus answer that never comes ends the run
	task automatic hang(input string what);
		error_cnt++;
		$display("CHECK FAILED at %0t: %s timed out", $time, what);
		summarize();
	endtask

	// pins pass two sync flops, up to two state updates and one output register: five edges is just enough
	task automatic settle;
		repeat (5) @(posedge MCLK);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!done && n < 50) begin
			@(posedge MCLK);
			n++;
			if (AWVALID && AWREADY) AWVALID <= 1'b0;
			if (WVALID && WREADY) WVALID <= 1'b0;
			if (BVALID && BREADY) begin
				done = 1'b1;
				r = BRESP;
				BREADY <= 1'b0;
			end
		end
		if (!done) hang("write");
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		while (!done && n < 50) begin
			@(posedge MCLK);
			n++;
			if (ARVALID && ARREADY) ARVALID <= 1'b0;
			if (RVALID && RREADY) begin
				done = 1'b1;
				d = RDATA;
				r = RRESP;
				RREADY <= 1'b0;
			end
		end
		if (!done) hang("read");
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge MCLK);
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_OFF, "drive in reset");
		RESET_N <= 1'b1;
		settle();
		// reset state and register map
		chk_pin(LOAD_SWITCH_ON, 1'b1, "load switch after reset");
		rd(chgsc_pkg::REG_STATUS, rdat, resp);
		chk_reg(rdat, 32'h0000_0080, "status after reset");
		chk_reg({30'h0, resp}, {30'h0, chgsc_pkg::AXI_OKAY}, "mapped read resp");
		rd(chgsc_pkg::REG_INT_MASK, rdat, resp);
		chk_reg(rdat, 32'h0, "mask after reset");
		rd(8'h10, rdat, resp);
		chk_reg({30'h0, resp}, {30'h0, chgsc_pkg::AXI_SLVERR}, "unmapped read resp");
		chk_reg(rdat, 32'h0, "unmapped read data");
		wr(8'h14, 32'h1, resp);
		chk_reg({30'h0, resp}, {30'h0, chgsc_pkg::AXI_SLVERR}, "unmapped write resp");
		$display("test reset done");
		// charger without battery is not recognised
		@(posedge MCLK);
		CHARGER_CONFIRMED <= 1'b1;
		settle();
		chk_pin(seen_pin, 1'b1, "seen without battery");
		chk_pin(EXTERNAL_POWER_OK, 1'b0, "power ok without battery");
		@(posedge MCLK);
		BATTERY_PRESENT_N <= 1'b0;
		settle();
		chk_pin(seen_pin, 1'b0, "seen with battery");
		chk_pin(phase_pin, 1'b0, "phase in full rate");
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_SATURATE, "full drive");
		chk_pin(EXTERNAL_POWER_OK, 1'b1, "power ok");
		rd(chgsc_pkg::REG_STATUS, rdat, resp);
		chk_reg(rdat, 32'h0000_01b2, "status full rate");
		// interrupt: pending but masked, then unmasked, then cleared
		chk_pin(IRQ, 1'b0, "irq masked");
		rd(chgsc_pkg::REG_INT_STAT, rdat, resp);
		chk_reg(rdat, 32'h1, "charger on event");
		wr(chgsc_pkg::REG_INT_MASK, 32'h1, resp);
		chk_reg({30'h0, resp}, {30'h0, chgsc_pkg::AXI_OKAY}, "mapped write resp");
		settle();
		chk_pin(IRQ, 1'b1, "irq unmasked");
		wr(chgsc_pkg::REG_INT_STAT, 32'h1, resp);
		settle();
		chk_pin(IRQ, 1'b0, "irq cleared");
		@(posedge MCLK);
		CELL_ABOVE_PHONE_ON <= 1'b0;
		settle();
		chk_pin(EXTERNAL_POWER_OK, 1'b0, "power ok low cell");
		$display("test detect done");
		// power limit, then trickle
		@(posedge MCLK);
		PASS_OVERPOWER <= 1'b1;
		settle();
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_REDUCED, "power limit");
		@(posedge MCLK);
		PASS_OVERPOWER <= 1'b0;
		CELL_HIGH_CHARGE <= 1'b1;
		settle();
		chk_pin(phase_pin, 1'b1, "phase in trickle");
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_REGULATE, "trickle drive");
		// disable pin, then re-enable restarts at full rate
		@(posedge MCLK);
		CHARGE_DISABLE <= 1'b1;
		settle();
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_OFF, "disabled drive");
		chk_pin(phase_pin, 1'b1, "phase disabled");
		@(posedge MCLK);
		CELL_HIGH_CHARGE <= 1'b0;
		CHARGE_DISABLE <= 1'b0;
		settle();
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_SATURATE, "restart full");
		chk_pin(phase_pin, 1'b0, "phase after restart");
		wr(chgsc_pkg::REG_CONTROL, 32'h1, resp);
		settle();
		chk_reg({30'h0, CHARGE_DRIVE}, chgsc_pkg::DRV_OFF, "soft disable");
		wr(chgsc_pkg::REG_CONTROL, 32'h0, resp);
		$display("test charge done");
		// chemistry selects the clamp
		for (int i = 0; i < 2; i++) begin
			@(posedge MCLK);
			CHEMISTRY_HIGH <= i[0];
			settle();
			chk_pin(TERMINATION_HIGH, i[0], "termination select");
		end
		$display("test chemistry done");
		// short request is ignored, long one latches the switch open
		@(posedge MCLK);
		HIBERNATE_REQUEST <= 1'b1;
		repeat (HIB / 2) @(posedge MCLK);
		HIBERNATE_REQUEST <= 1'b0;
		settle();
		chk_pin(LOAD_SWITCH_ON, 1'b1, "short request");
		@(posedge MCLK);
		HIBERNATE_REQUEST <= 1'b1;
		repeat (HIB + 8) @(posedge MCLK);
		HIBERNATE_REQUEST <= 1'b0;
		settle();
		chk_pin(LOAD_SWITCH_ON, 1'b0, "hibernate latched");
		@(posedge MCLK);
		HIBERNATE_RELEASE_N <= 1'b0;
		repeat (3) @(posedge MCLK);
		HIBERNATE_RELEASE_N <= 1'b1;
		settle();
		chk_pin(LOAD_SWITCH_ON, 1'b1, "hibernate released");
		@(posedge MCLK);
		CELL_ABOVE_LOW <= 1'b0;
		settle();
		chk_pin(LOAD_SWITCH_ON, 1'b0, "undervoltage");
		@(posedge MCLK);
		CELL_ABOVE_LOW <= 1'b1;
		LOAD_OVERCURRENT <= 1'b1;
		settle();
		chk_pin(LOAD_SWITCH_ON, 1'b0, "overload");
		// trickle entry, hibernate latch and overload rise are pending, all masked
		rd(chgsc_pkg::REG_INT_STAT, rdat, resp);
		chk_reg(rdat, (32'h1 << chgsc_pkg::EV_TRICKLE) | (32'h1 << chgsc_pkg::EV_HIBERNATE) |
			(32'h1 << chgsc_pkg::EV_LOAD_FAULT), "later events");
		chk_pin(IRQ, 1'b0, "irq stays masked");
		$display("test load switch done");
		summarize();
	end
endmodule // chgsc_top_test
`default_nettype wire
